// *** timer_pkg.sv ***
package timer_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_TIMERS = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00; // timer_control_reg
  localparam logic [ADDR_W-1:0] OFF_MODE    = 8'h04; // timer_mode_reg
  localparam logic [ADDR_W-1:0] OFF_LO_T0   = 8'h08; // count_low_byte_t0
  localparam logic [ADDR_W-1:0] OFF_HI_T0   = 8'h0c; // count_high_byte_t0
  localparam logic [ADDR_W-1:0] OFF_LO_T1   = 8'h10; // count_low_byte_t1
  localparam logic [ADDR_W-1:0] OFF_HI_T1   = 8'h14; // count_high_byte_t1

  // ----------------------------------------------------------------
  // Field positions; timer n uses base + n * stride
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_POS    = 4; // run_bit_t0, run_bit_t1 at 6
  localparam int CTRL_OVF_POS    = 5; // overflow flag t0, t1 at 7
  localparam int CTRL_STRIDE     = 2;
  localparam int MODE_M16_POS    = 0; // 0: 13-bit, 1: 16-bit
  localparam int MODE_GATE_POS   = 3; // gate_select_t0, t1 at 7
  localparam int MODE_STRIDE     = 4;

  // ----------------------------------------------------------------
  // Counter layout and reset values
  // ----------------------------------------------------------------
  localparam int CNT_W    = 16;
  localparam int LOW13_W  = 5;  // low byte bits used in 13-bit mode
  localparam int CNT13_W  = 13;
  localparam logic [CNT_W-1:0]   CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0]   CNT16_MAX = 16'hffff;
  localparam logic [CNT13_W-1:0] CNT13_MAX = 13'h1fff;
  localparam logic [CNT13_W-1:0] CNT13_ONE = 13'h0001;
  localparam logic [CNT_W-1:0]   CNT16_ONE = 16'h0001;

  // ----------------------------------------------------------------
  // Responses and register selector
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum {
    SEL_CONTROL, SEL_MODE, SEL_LO0, SEL_HI0, SEL_LO1, SEL_HI1, SEL_NONE
  } reg_sel_e;

endpackage

// *** timer_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// Control and state of one counter, between the register file and a unit
interface timer_if;
  import timer_pkg::*;
  logic              run;
  logic              gate;
  logic              mode16;
  logic              ext_gate;
  logic              load_lo;
  logic              load_hi;
  logic [7:0]        wdata;
  logic [CNT_W-1:0]  count;
  logic              ovf;

  modport ctrl (output run, gate, mode16, ext_gate, load_lo, load_hi,
                wdata, input count, ovf);
  modport unit (input run, gate, mode16, ext_gate, load_lo, load_hi,
                wdata, output count, ovf);
endinterface

`default_nettype wire

// *** timer_unit.sv ***
`timescale 1ns/1ps
`default_nettype none

// One counter, 13-bit or 16-bit, with run and gate qualification
module timer_unit (
  input  wire logic aclk,
  input  wire logic aresetn,
  timer_if.unit     tif
);
  import timer_pkg::*;

  logic [CNT_W-1:0]   count_q;
  logic [CNT_W-1:0]   count_d;
  logic [CNT13_W-1:0] cnt13;
  logic [CNT13_W-1:0] inc13;
  logic [CNT_W-1:0]   next13;
  logic               enable;
  logic               at_max;

  // ----------------------------------------------------------------
  // Qualification and increment
  // ----------------------------------------------------------------
  // Gate high with gate select lets the pin time a pulse width
  assign enable = tif.run & (~tif.gate | tif.ext_gate);
  // 13-bit count is the high byte over the low five bits
  assign cnt13  = {count_q[CNT_W-1:8], count_q[LOW13_W-1:0]};
  assign inc13  = cnt13 + CNT13_ONE;
  // Upper three low-byte bits are left alone in 13-bit mode
  assign next13 = {inc13[CNT13_W-1:LOW13_W], count_q[7:LOW13_W],
                   inc13[LOW13_W-1:0]};
  assign at_max = tif.mode16 ? (count_q == CNT16_MAX)
                             : (cnt13 == CNT13_MAX);
  assign count_d = tif.mode16 ? count_q + CNT16_ONE : next13;

  // Software loads win over counting; wrap to zero keeps running
  assign tif.ovf   = enable & at_max & ~tif.load_lo & ~tif.load_hi;
  assign tif.count = count_q;

  // ----------------------------------------------------------------
  // Count register
  // ----------------------------------------------------------------
  // Run alone never touches the count; only loads and ticks do
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= CNT_RESET;
    end else if (tif.load_lo) begin
      count_q[7:0] <= tif.wdata;
    end else if (tif.load_hi) begin
      count_q[CNT_W-1:8] <= tif.wdata;
    end else if (enable) begin
      count_q <= count_d;
    end
  end

endmodule

`default_nettype wire

// *** gated_counter_timer_pair.sv ***
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - timer 0 counts when run and (ungated or pin high)
// - gate select lets pin level control counting
// - setting run leaves the count untouched
// - timer 1 builds 13-bit count like timer 0
// - timer 1 has own identical control bits
// - mode 1 uses full 16-bit count
// - mode 1 run and gating same as mode 0
module gated_counter_timer_pair (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ext_gate_input_t0,
  input  wire logic                         ext_gate_input_t1,
  input  wire logic [timer_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [timer_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [timer_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [timer_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // Address decode, shared by the read and write paths
  // ----------------------------------------------------------------
  function automatic reg_sel_e decode(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_CONTROL: decode = SEL_CONTROL;
      OFF_MODE:    decode = SEL_MODE;
      OFF_LO_T0:   decode = SEL_LO0;
      OFF_HI_T0:   decode = SEL_HI0;
      OFF_LO_T1:   decode = SEL_LO1;
      OFF_HI_T1:   decode = SEL_HI1;
      default:     decode = SEL_NONE;
    endcase
  endfunction

  logic [ADDR_W-1:0]     awaddr_q;
  logic                  aw_held_q;
  logic [7:0]            wdata_q;
  logic                  wlane0_q;
  logic                  w_held_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [1:0]            rresp_q;
  logic [DATA_W-1:0]     rdata_q;
  logic [NUM_TIMERS-1:0] run_q;
  logic [NUM_TIMERS-1:0] gate_q;
  logic [NUM_TIMERS-1:0] mode16_q;
  logic [NUM_TIMERS-1:0] ovf_q;
  logic [NUM_TIMERS-1:0] ovf_set;
  logic [NUM_TIMERS-1:0] ext_gate;
  logic [CNT_W-1:0]      count [NUM_TIMERS];

  // ----------------------------------------------------------------
  // Write channel handshake
  // ----------------------------------------------------------------
  // Address and data are taken in either order and held until commit
  wire      aw_take   = s_axi_awvalid & s_axi_awready;
  wire      w_take    = s_axi_wvalid & s_axi_wready;
  wire      wr_commit = aw_held_q & w_held_q & ~bvalid_q;
  reg_sel_e wr_sel;
  assign wr_sel = decode(awaddr_q);
  wire      wr_en     = wr_commit & wlane0_q; // data lives in byte lane 0
  wire      wr_ctrl   = wr_en & (wr_sel == SEL_CONTROL);
  wire      wr_mode   = wr_en & (wr_sel == SEL_MODE);

  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Hold address and data, answer one cycle after both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wlane0_q  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wlane0_q <= s_axi_wstrb[0];
      end
      if (wr_commit) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and mode registers
  // ----------------------------------------------------------------
  // Flags: hardware set beats a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q    <= '0;
      gate_q   <= '0;
      mode16_q <= '0;
      ovf_q    <= '0;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (wr_ctrl) begin
          run_q[i] <= wdata_q[CTRL_RUN_POS + CTRL_STRIDE*i];
        end
        if (wr_mode) begin
          gate_q[i]   <= wdata_q[MODE_GATE_POS + MODE_STRIDE*i];
          mode16_q[i] <= wdata_q[MODE_M16_POS + MODE_STRIDE*i];
        end
        if (ovf_set[i]) begin
          ovf_q[i] <= 1'b1;
        end else if (wr_ctrl && wdata_q[CTRL_OVF_POS + CTRL_STRIDE*i]) begin
          ovf_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter units
  // ----------------------------------------------------------------
  assign ext_gate = {ext_gate_input_t1, ext_gate_input_t0};

  timer_if tif [NUM_TIMERS] ();

  // Both timers are the same unit with their own bits and pin
  for (genvar g = 0; g < NUM_TIMERS; g++) begin : gen_timer
    reg_sel_e lo_sel;
    reg_sel_e hi_sel;
    assign lo_sel = (g == 0) ? SEL_LO0 : SEL_LO1;
    assign hi_sel = (g == 0) ? SEL_HI0 : SEL_HI1;
    assign tif[g].run      = run_q[g];
    assign tif[g].gate     = gate_q[g];
    assign tif[g].mode16   = mode16_q[g];
    assign tif[g].ext_gate = ext_gate[g];
    assign tif[g].load_lo  = wr_en & (wr_sel == lo_sel);
    assign tif[g].load_hi  = wr_en & (wr_sel == hi_sel);
    assign tif[g].wdata    = wdata_q;
    assign count[g]        = tif[g].count;
    assign ovf_set[g]      = tif[g].ovf;

    timer_unit u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tif     (tif[g])
    );
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  reg_sel_e          rd_sel;
  logic [7:0]        ctrl_view;
  logic [7:0]        mode_view;
  logic [7:0]        rd_byte;
  assign rd_sel = decode(s_axi_araddr);

  // Assemble control and mode bytes from the per-timer bits
  always_comb begin
    ctrl_view = '0;
    mode_view = '0;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      ctrl_view[CTRL_RUN_POS + CTRL_STRIDE*i] = run_q[i];
      ctrl_view[CTRL_OVF_POS + CTRL_STRIDE*i] = ovf_q[i];
      mode_view[MODE_GATE_POS + MODE_STRIDE*i] = gate_q[i];
      mode_view[MODE_M16_POS + MODE_STRIDE*i]  = mode16_q[i];
    end
  end

  assign rd_byte = (rd_sel == SEL_CONTROL) ? ctrl_view :
                   (rd_sel == SEL_MODE)    ? mode_view :
                   (rd_sel == SEL_LO0)     ? count[0][7:0] :
                   (rd_sel == SEL_HI0)     ? count[0][CNT_W-1:8] :
                   (rd_sel == SEL_LO1)     ? count[1][7:0] :
                   (rd_sel == SEL_HI1)     ? count[1][CNT_W-1:8] : 8'h00;

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Data captured at the address edge; reads have no side effects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {{(DATA_W-8){1'b0}}, rd_byte};
      rresp_q  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** gated_counter_timer_pair_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Bus handshake checks on the top ports
// ------------------------------------------------------------
module gated_counter_timer_pair_monitor (
  input wire logic                         aclk,
  input wire logic                         aresetn,
  input wire logic                         s_axi_awvalid,
  input wire logic                         s_axi_awready,
  input wire logic                         s_axi_wvalid,
  input wire logic                         s_axi_wready,
  input wire logic [1:0]                   s_axi_bresp,
  input wire logic                         s_axi_bvalid,
  input wire logic                         s_axi_bready,
  input wire logic [timer_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                         s_axi_arvalid,
  input wire logic                         s_axi_arready,
  input wire logic [timer_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]                   s_axi_rresp,
  input wire logic                         s_axi_rvalid,
  input wire logic                         s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Write is taken as one step, its answer comes two edges later
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (s_write_taken |=> !s_axi_bvalid ##1
    s_axi_bvalid) else $error("write answer late or early");
  a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped or changed");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
  a_b_retires: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("write answer not retired");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_aw_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken too soon");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
    else $error("upper read bits not zero");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > timer_pkg::OFF_HI_T1 |=>
    s_axi_rresp == 2'b10 && s_axi_rdata == 0) else $error("unmapped read");
endmodule

bind gated_counter_timer_pair gated_counter_timer_pair_monitor i_mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

`default_nettype wire

// *** gate_pin_source.sv ***
`timescale 1ns/1ps
`default_nettype none

// Far-side pulse source on the two gate pins
module gate_pin_source (
  input  wire logic       aclk,
  input  wire logic [1:0] level_req,
  output logic      [1:0] gate_pins
);
  // Pins move just after an edge, like a synchronous pulse source
  always @(posedge aclk) begin
    gate_pins <= level_req;
  end
endmodule

`default_nettype wire

// *** tb_gated_counter_timer_pair.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_gated_counter_timer_pair;
  import timer_pkg::*;
  typedef struct {bit t; bit m16; bit gate; bit pin; logic [15:0] start;
                  logic [15:0] cnt; bit ovf;} row_s;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, gate_pins, resp;
  logic [1:0]  pin_req = 2'b00;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, base;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [31:0] mode_w;
  int          n_mismatch = 0, check_count = 0;
  // Timer, 16-bit mode, gate, pin, start, then count and flag after ten
  // increments from run commit to stop commit when enabled
  row_s rows [8] = '{
    '{0,0,0,0,16'hffe0,16'hffea,0}, '{0,1,0,0,16'hfffa,16'h0004,1},
    '{0,0,1,0,16'h1234,16'h1234,0}, '{0,1,1,1,16'h00ff,16'h0109,0},
    '{1,0,0,1,16'hfffc,16'h00e6,1}, '{1,1,1,0,16'h5555,16'h5555,0},
    '{1,0,1,1,16'h0010,16'h001a,0}, '{1,1,0,0,16'hfff6,16'h0000,1}};

  gated_counter_timer_pair i_dut (.aclk, .aresetn,
    .ext_gate_input_t0(gate_pins[0]), .ext_gate_input_t1(gate_pins[1]),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  gate_pin_source i_pins (.aclk, .level_req(pin_req), .gate_pins);

  initial begin
    forever #4 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Each channel is released at the edge that takes it
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Generous bound: the whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    $display("watchdog expired");
    complete_run();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) begin
      rdr(8'(a));
      check("reset value", rd, 32'h0);
    end
    $display("reset values done");
    foreach (rows[i]) begin
      base = OFF_LO_T0 + 8'(8 * rows[i].t);
      mode_w = 32'(rows[i].m16) << (4 * rows[i].t)
        | 32'(rows[i].gate) << (3 + 4 * rows[i].t);
      wr(OFF_CONTROL, 32'ha0);
      pin_req[rows[i].t] <= rows[i].pin;
      wr(OFF_MODE, mode_w);
      rdr(OFF_MODE);
      check("mode", rd, mode_w);
      wr(base, 32'(rows[i].start[7:0]));
      wr(base + 8'h4, 32'(rows[i].start[15:8]));
      wr(OFF_CONTROL, 32'h1 << (4 + 2 * rows[i].t));
      // The read takes three edges, so the run window stays ten edges
      rdr(OFF_CONTROL);
      check("run bit", rd, 32'h1 << (4 + 2 * rows[i].t));
      repeat (3) @(posedge aclk);
      wr(OFF_CONTROL, 32'h0);
      rdr(base);
      check("count low", rd, 32'(rows[i].cnt[7:0]));
      rdr(base + 8'h4);
      check("count high", rd, 32'(rows[i].cnt[15:8]));
      rdr(OFF_CONTROL);
      check("ovf flag", rd, 32'(rows[i].ovf) << (5+2*rows[i].t));
      $display("row %0d done", i);
    end
    wr(OFF_CONTROL, 32'ha0);
    rdr(OFF_CONTROL);
    check("flag cleared", rd, 32'h0);
    wr(8'h18, 32'hff);
    check("unmapped write", 32'(resp), 32'h2);
    rdr(8'h40);
    check("unmapped read", rd | 32'(resp) << 8, 32'h200);
    $display("unmapped access done");
    // Byte lane 0 off: answered OKAY, count keeps its value
    s_axi_wstrb <= 4'h0;
    wr(OFF_LO_T0, 32'h77);
    s_axi_wstrb <= 4'h1;
    check("masked write resp", 32'(resp), 32'h0);
    rdr(OFF_LO_T0);
    check("masked write", rd, 32'h09);
    $display("masked write done");
    wr(OFF_LO_T0, 32'h33);
    wr(OFF_CONTROL, 32'h10);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(OFF_LO_T0);
    check("count after reset", rd, 32'h0);
    $display("mid-run reset done");
    complete_run();
  end
endmodule

`default_nettype wire
